// >>> rtl/ugrl_pkg.sv
// Purpose: shared constants for the user glyph RAM lookup block
// Assumes: 8-bit character codes, 6-bit glyph RAM address, 5-dot rows
// Notes: widths, field positions, cursor rows, dot and read data reset values and the lookup latency live here
package ugrl_pkg;
  // widths
  localparam int CODE_W = 8; // character code from display text ram
  localparam int ADDR_W = 6; // user glyph ram address width
  localparam int DATA_W = 8; // user glyph ram word width
  localparam int DOT_W = 5; // dots in one pattern row
  localparam int ROW_W = 4; // row index width, wide enough for 5x10
  localparam int DEPTH = 64; // words in the user glyph ram

  // field positions inside the character code
  localparam int CODE_SEL_LSB = 4; // bits 4..7 all zero picks the user glyph ram
  localparam int CODE_SEL_MSB = 7;

  // row numbers that carry the cursor
  localparam logic [ROW_W-1:0] CURSOR_ROW_5X8 = 4'h7; // eighth row
  localparam logic [ROW_W-1:0] CURSOR_ROW_5X10 = 4'ha; // eleventh row
  localparam logic [ROW_W-1:0] LAST_ROW_5X10 = 4'ha; // rows above this are blank

  // reset values
  localparam logic [DOT_W-1:0] DOTS_RST = 5'h00;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;

  // pipeline: one cycle ram read, one cycle output register
  localparam int LOOKUP_LATENCY = 2;
endpackage

// >>> rtl/ugrl_glyph_mem.sv
// Purpose: user glyph ram storage, one write port and one registered read port
// Assumes: single clock; read and write of one address in a cycle returns old data
// Notes: read data come straight out of a register
`timescale 1ns/1ps
module ugrl_glyph_mem #(
  parameter int ADDR_W = ugrl_pkg::ADDR_W,
  parameter int DATA_W = ugrl_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // host write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // scan read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  // storage array, not reset: glyph contents are up to the host
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;

  // read is always performed; old data wins on a same-address write
  always_comb
  begin
    rd_data_next = mem[rd_addr];
  end

  // array write, kept apart so the array needs no reset
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_data_reg <= ugrl_pkg::RD_DATA_RST;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

// >>> rtl/ugrl_lookup.sv
// Purpose: turns a character code and row index into five dots of a user glyph
// Assumes: scan and host ports come from logic on clk_sys, so no synchronisers
// Notes: fixed font codes only raise a flag; the rom lookup lives elsewhere
`timescale 1ns/1ps
module ugrl_lookup (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // host glyph write port
  input wire logic glyph_wr_en,
  input wire logic [ugrl_pkg::ADDR_W-1:0] glyph_wr_addr,
  input wire logic [ugrl_pkg::DATA_W-1:0] glyph_wr_data,
  // scan request
  input wire logic scan_valid,
  input wire logic [ugrl_pkg::CODE_W-1:0] char_code,
  input wire logic [ugrl_pkg::ROW_W-1:0] row_index,
  input wire logic font_5x10,
  input wire logic cursor_here,
  // scan answer
  output logic dots_valid,
  output logic [ugrl_pkg::DOT_W-1:0] dots,
  output logic fixed_font_sel
);
  // builds the glyph ram address from code and row for either font format
  function automatic logic [ugrl_pkg::ADDR_W-1:0] glyph_addr(
    input logic [ugrl_pkg::CODE_W-1:0] code,
    input logic [ugrl_pkg::ROW_W-1:0] row,
    input logic is_5x10
  );
    logic [ugrl_pkg::ADDR_W-1:0] a;
    if (is_5x10)
    begin
      a = {code[2:1], row[3:0]};
    end
    else
    begin
      a = {code[2:0], row[2:0]};
    end
    return a;
  endfunction

  // true when this row of the format carries the cursor
  function automatic logic is_cursor_row(
    input logic [ugrl_pkg::ROW_W-1:0] row,
    input logic is_5x10
  );
    logic hit;
    if (is_5x10)
    begin
      hit = (row == ugrl_pkg::CURSOR_ROW_5X10);
    end
    else
    begin
      hit = (row[2:0] == ugrl_pkg::CURSOR_ROW_5X8[2:0]);
    end
    return hit;
  endfunction

  // ram address for the request in this cycle
  logic [ugrl_pkg::ADDR_W-1:0] ram_rd_addr;
  // word read out of the glyph ram, valid one cycle after the request
  logic [ugrl_pkg::DATA_W-1:0] ram_rd_data;

  // stage 1: request attributes held while the ram reads
  logic s1_valid_reg, s1_valid_next;
  logic s1_fixed_reg, s1_fixed_next; // code outside the user range
  logic s1_cursor_reg, s1_cursor_next; // cursor must be merged on this row
  logic s1_blank_reg, s1_blank_next; // row past the last 5x10 row
  // stage 2: registered answer
  logic dots_valid_reg, dots_valid_next;
  logic [ugrl_pkg::DOT_W-1:0] dots_reg, dots_next;
  logic fixed_reg, fixed_next;

  // address decode for the ram
  always_comb
  begin
    ram_rd_addr = glyph_addr(char_code, row_index, font_5x10);
  end

  // glyph storage; host writes go straight in, no ordering with reads
  ugrl_glyph_mem #(
    .ADDR_W(ugrl_pkg::ADDR_W),
    .DATA_W(ugrl_pkg::DATA_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(glyph_wr_en),
    .wr_addr(glyph_wr_addr),
    .wr_data(glyph_wr_data),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_rd_data)
  );

  // stage 1 next values: classify the request while the ram reads
  always_comb
  begin
    s1_valid_next = scan_valid;
    // any set bit among 7:4 sends the code to the fixed font
    s1_fixed_next = |char_code[ugrl_pkg::CODE_SEL_MSB:ugrl_pkg::CODE_SEL_LSB];
    // cursor only counts on the format's cursor row
    s1_cursor_next = cursor_here && is_cursor_row(row_index, font_5x10);
    // rows 11..15 of a 5x10 cell are don't-care in the ram, show nothing
    s1_blank_next = font_5x10 && (row_index > ugrl_pkg::LAST_ROW_5X10);
  end

  // stage 1 registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s1_valid_reg <= 1'b0;
      s1_fixed_reg <= 1'b0;
      s1_cursor_reg <= 1'b0;
      s1_blank_reg <= 1'b0;
    end
    else
    begin
      s1_valid_reg <= s1_valid_next;
      s1_fixed_reg <= s1_fixed_next;
      s1_cursor_reg <= s1_cursor_next;
      s1_blank_reg <= s1_blank_next;
    end
  end

  // stage 2 next values: form the dots from the ram word
  always_comb
  begin
    dots_valid_next = s1_valid_reg;
    fixed_next = s1_valid_reg && s1_fixed_reg;
    if (!s1_valid_reg || s1_fixed_reg || s1_blank_reg)
    begin
      // idle, fixed font or blank row: no user dots
      dots_next = ugrl_pkg::DOTS_RST;
    end
    else if (s1_cursor_reg)
    begin
      // stray ones written by the host on this row make no difference, all five dots light
      dots_next = ram_rd_data[ugrl_pkg::DOT_W-1:0] | {ugrl_pkg::DOT_W{1'b1}};
    end
    else
    begin
      // bits 7:5 dropped, bit 4 stays leftmost dot, a one lights
      dots_next = ram_rd_data[ugrl_pkg::DOT_W-1:0];
    end
  end

  // stage 2 registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dots_valid_reg <= 1'b0;
      dots_reg <= ugrl_pkg::DOTS_RST;
      fixed_reg <= 1'b0;
    end
    else
    begin
      dots_valid_reg <= dots_valid_next;
      dots_reg <= dots_next;
      fixed_reg <= fixed_next;
    end
  end

  // outputs straight from flip-flops
  assign dots_valid = dots_valid_reg;
  assign dots = dots_reg;
  assign fixed_font_sel = fixed_reg;

  // address layout in 5x8 format
  property p_addr_5x8;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && !font_5x10) |-> (ram_rd_addr == {char_code[2:0], row_index[2:0]});
  endproperty
  a_addr_5x8: assert property (p_addr_5x8) else $error("5x8 glyph address wrong");

  // address layout in 5x10 format
  property p_addr_5x10;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && font_5x10) |-> (ram_rd_addr == {char_code[2:1], row_index});
  endproperty
  a_addr_5x10: assert property (p_addr_5x10) else $error("5x10 glyph address wrong");

  // answer comes exactly two cycles after the request
  property p_latency;
    @(posedge clk_sys) disable iff (reset)
    scan_valid |-> ##2 dots_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("answer not two cycles after request");

  // fixed font flag follows code bits 7:4
  property p_fixed_sel;
    @(posedge clk_sys) disable iff (reset)
    scan_valid |-> ##2 (fixed_font_sel == ($past(char_code[7:4], 2) != 4'h0));
  endproperty
  a_fixed_sel: assert property (p_fixed_sel) else $error("fixed font select wrong");

  // 5x8 cursor row with cursor present lights all dots
  property p_cursor_5x8;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && !font_5x10 && char_code[7:4] == 4'h0 && row_index[2:0] == 3'h7 && cursor_here)
      |-> ##2 (dots == 5'h1f);
  endproperty
  a_cursor_5x8: assert property (p_cursor_5x8) else $error("5x8 cursor row not lit");

  // 5x10 cursor row with cursor present lights all dots
  property p_cursor_5x10;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && font_5x10 && char_code[7:4] == 4'h0 && row_index == 4'ha && cursor_here)
      |-> ##2 (dots == 5'h1f);
  endproperty
  a_cursor_5x10: assert property (p_cursor_5x10) else $error("5x10 cursor row not lit");

  // 5x10 rows past the eleventh stay dark
  property p_blank_rows;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && font_5x10 && row_index > 4'ha) |-> ##2 (dots == 5'h00);
  endproperty
  a_blank_rows: assert property (p_blank_rows) else $error("5x10 row past eleventh shows dots");

  // ordinary 5x8 user row shows the ram bits 4:0 as read
  property p_plain_row;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && !font_5x10 && char_code[7:4] == 4'h0 && !cursor_here)
      |-> ##2 (dots == $past(ram_rd_data[4:0]));
  endproperty
  a_plain_row: assert property (p_plain_row) else $error("row dots differ from ram data");

  // fixed font codes produce no user dots
  property p_fixed_dark;
    @(posedge clk_sys) disable iff (reset)
    (scan_valid && char_code[7:4] != 4'h0) |-> ##2 (dots == 5'h00 && fixed_font_sel);
  endproperty
  a_fixed_dark: assert property (p_fixed_dark) else $error("fixed font code shows user dots");
endmodule

// >>> testbench/ugrl_host_model.sv
// Purpose: host model loading user glyph ram rows
// Assumes: writes launched at the falling edge of clk_sys
// Notes: cursor rows kept clear unless a dirty load is asked for
`timescale 1ns/1ps
module ugrl_host_model (
  // clock
  input wire logic clk_sys,
  // glyph write port
  output logic glyph_wr_en,
  output logic [ugrl_pkg::ADDR_W-1:0] glyph_wr_addr,
  output logic [ugrl_pkg::DATA_W-1:0] glyph_wr_data
);
  // idle bus at time zero
  initial
  begin
    glyph_wr_en = 1'b0;
    glyph_wr_addr = 6'h00;
    glyph_wr_data = 8'h00;
  end

  // one word a cycle; strobe stays high between loads
  task automatic load(input logic [5:0] a, input logic [7:0] d, input logic f, input logic dirty);
    logic cur;
    begin
      cur = f ? (a[3:0] == 4'ha) : (a[2:0] == 3'h7);
      @(negedge clk_sys);
      glyph_wr_en = 1'b1;
      glyph_wr_addr = a;
      glyph_wr_data = (cur && !dirty) ? (d & 8'he0) : d;
    end
  endtask

  // released lines flip so stale values never look valid
  task automatic release_bus();
    @(negedge clk_sys);
    glyph_wr_en = 1'b0;
    glyph_wr_addr = ~glyph_wr_addr;
    glyph_wr_data = ~glyph_wr_data;
  endtask
endmodule

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the glyph lookup
// Assumes: answers come in request order
// Notes: expectations come from a bench copy of glyph ram
`timescale 1ns/1ps
module testbench;
  logic clk_sys, reset, scan_valid, font_5x10, cursor_here;
  logic glyph_wr_en, dots_valid, fixed_font_sel;
  logic [7:0] char_code, glyph_wr_data;
  logic [3:0] row_index;
  logic [5:0] glyph_wr_addr;
  logic [4:0] dots;
  logic [7:0] mirror [64]; // bench copy of glyph ram
  logic [5:0] exp_q [$]; // pending {fixed_font_sel, dots}
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] rng = 32'h0d008684;

  // 50 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ugrl_lookup ugrl_lookup_inst (.clk_sys(clk_sys), .reset(reset), .glyph_wr_en(glyph_wr_en),
    .glyph_wr_addr(glyph_wr_addr), .glyph_wr_data(glyph_wr_data), .scan_valid(scan_valid),
    .char_code(char_code), .row_index(row_index), .font_5x10(font_5x10), .cursor_here(cursor_here),
    .dots_valid(dots_valid), .dots(dots), .fixed_font_sel(fixed_font_sel));
  ugrl_host_model ugrl_host_model_inst (.clk_sys(clk_sys), .glyph_wr_en(glyph_wr_en),
    .glyph_wr_addr(glyph_wr_addr), .glyph_wr_data(glyph_wr_data));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // follow every word the host stores
  always @(posedge clk_sys)
    if (glyph_wr_en === 1'b1)
      mirror[glyph_wr_addr] <= glyph_wr_data;

  // reference row; bits 7:5 never reach the dots
  function automatic logic [5:0] exp_row(input logic [7:0] c, input logic [3:0] r, input logic f, input logic k);
    logic [4:0] d;
    if (c[7:4] != 4'h0)
      return 6'h20;
    if (!f)
    begin
      d = mirror[{c[2:0], r[2:0]}][4:0];
      if (r[2:0] == 3'h7 && k)
        d = 5'h1f;
    end
    else
    begin
      d = mirror[{c[2:1], r}][4:0];
      if (r == 4'ha && k)
        d = 5'h1f;
      if (r > 4'ha)
        d = 5'h00;
    end
    return {1'b0, d};
  endfunction

  // one request a cycle, cursor chosen at random
  task automatic scan(input logic [7:0] c, input logic [3:0] r, input logic f);
    @(negedge clk_sys);
    rng = xorshift(rng);
    scan_valid = 1'b1;
    char_code = c;
    row_index = r;
    font_5x10 = f;
    cursor_here = rng[0];
    exp_q.push_back(exp_row(c, r, f, rng[0]));
  endtask

  // each answer is paired with the oldest note
  always @(negedge clk_sys)
    if (dots_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray dots_valid", 8'h01, 8'h00);
      else
        check("fixed_font_sel and dots", {2'b00, fixed_font_sel, dots}, {2'b00, exp_q.pop_front()});
    end

  // hang guard
  initial
  begin
    #(50 * 90000);
    error_cnt++;
    give_verdict();
  end

  // passes: 5x8 clean, 5x10 clean, 5x8 dirty, 5x10 dirty cursor rows
  initial
  begin
    reset = 1'b1;
    scan_valid = 1'b0;
    char_code = 8'h00;
    row_index = 4'h0;
    font_5x10 = 1'b0;
    cursor_here = 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    check("dots_valid after reset", {7'h00, dots_valid}, 8'h00);
    check("dots after reset", {3'h0, dots}, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      for (int a = 0; a < 64; a++)
      begin
        rng = xorshift(rng);
        ugrl_host_model_inst.load(a[5:0], rng[7:0], p[0], p[1]);
      end
      ugrl_host_model_inst.release_bus();
      for (int c = 0; c < 256; c++)
        for (int r = 0; r < 16; r++)
          scan(c[7:0], r[3:0], p[0]);
      @(negedge clk_sys);
      scan_valid = 1'b0;
      for (int w = 0; w < 8 && exp_q.size() != 0; w++)
        @(posedge clk_sys);
    end
    if (exp_q.size() != 0)
      check("answers missing", 8'h01, 8'h00);
    give_verdict();
  end
endmodule
